// ### core/async_serial_consts.vh
// Constants for the asynchronous serial transceiver.
// Assumes inclusion by the transceiver core only.
`ifndef ASYNC_SERIAL_CONSTS_VH
`define ASYNC_SERIAL_CONSTS_VH

// Register indices; byte address is four times the index.
`define REG_MODE   3'h0
`define REG_STATUS 3'h1
`define REG_TXHOLD 3'h2
`define REG_RXDATA 3'h3
`define REG_BAUD   3'h4

// Mode register fields.
`define MODE_ENABLE 15
`define MODE_FMT_HI 2
`define MODE_FMT_LO 1
`define MODE_STOP2  0

// Status and control register fields.
`define STA_TXISEL  15
`define STA_BREAK   11
`define STA_TXEN    10
`define STA_TXFULL  9
`define STA_TXEMPTY 8
`define STA_RXISEL1 7
`define STA_RXISEL0 6
`define STA_ADDR    5
`define STA_RXIDLE  4
`define STA_PARITY_ERROR_FLAG    3
`define STA_FRAMING_ERROR_FLAG    2
`define STA_OVERRUN_FLAG    1
`define STA_RXAVAIL 0

// Frame format encodings.
`define FMT_8N 2'h0
`define FMT_8E 2'h1
`define FMT_8O 2'h2
`define FMT_9N 2'h3

// Reset values.
`define MODE_RST 16'h0000
`define BAUD_RST 16'h0000

// Oversampling: last tick index of a bit and the mid-start sample tick.
`define TICK_LAST 4'hf
`define TICK_MID  4'h7

`endif

// ### core/async_serial_transceiver.v
// Asynchronous serial transceiver core with Avalon-MM register slave.
// Assumes serialIn comes from a pin and needs synchronising; one clock.
`timescale 1ns/1ps
`include "async_serial_consts.vh"

module async_serial_transceiver #(
  parameter DEPTH = 4,
  parameter PW    = 2
)(
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire [2:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [15:0] writedata,
  output reg  [15:0] readdata,
  output reg         waitrequest,
  input  wire        serialIn,
  output reg         serialOut,
  output reg         txIrqPulse,
  output reg         rxIrqPulse
);

  localparam [1:0] RX_IDLE  = 2'h0;
  localparam [1:0] RX_START = 2'h1;
  localparam [1:0] RX_DATA  = 2'h2;
  localparam [1:0] RX_WAIT  = 2'h3;
  localparam [PW:0] FULL_CNT = DEPTH;

  // Builds the frame LSB first, start bit at bit 0, idle ones above.
  function [12:0] frameBits;
    input [8:0] d;
    input [1:0] f;
    begin
      case (f)
        `FMT_8E: frameBits = {3'h7, ^d[7:0], d[7:0], 1'b0};
        `FMT_8O: frameBits = {3'h7, ~^d[7:0], d[7:0], 1'b0};
        `FMT_9N: frameBits = {3'h7, d[8:0], 1'b0};
        default: frameBits = {4'hf, d[7:0], 1'b0};
      endcase
    end
  endfunction

  // Frame length in bits, start and stop bits included.
  function [3:0] frameLen;
    input [1:0] f;
    input       s;
    begin
      frameLen = 4'ha + {3'h0, f != `FMT_8N} + {3'h0, s};
    end
  endfunction

  // Configuration and control state.
  reg [15:0] modeReg_ff;
  reg [15:0] baudDiv_ff;
  reg        txIsel_ff;
  reg        brk_ff;
  reg        txEn_ff;
  reg [1:0]  rxIsel_ff;
  reg        addrDet_ff;
  reg        overrun_flag_ff;
  wire       enable = modeReg_ff[`MODE_ENABLE];
  wire [1:0] fmt    = modeReg_ff[`MODE_FMT_HI:`MODE_FMT_LO];
  wire       stop2  = modeReg_ff[`MODE_STOP2];
  wire [3:0] fLen   = frameLen(fmt, stop2);

  // Bus decode: a request is taken on the edge where waitrequest is low.
  wire taken  = (read | write) & ~waitrequest;
  wire wrTake = taken & write;
  wire wrMode = wrTake & (address == `REG_MODE);
  wire wrSta  = wrTake & (address == `REG_STATUS);
  wire wrTx   = wrTake & (address == `REG_TXHOLD);
  wire wrBaud = wrTake & (address == `REG_BAUD);

  // Baud tick at sixteen times the bit rate; cleared while disabled.
  reg  [15:0] baudCnt_ff;
  wire        tick = enable & (baudCnt_ff == baudDiv_ff);

  // Transmit buffer and shifter.
  reg  [8:0]  txMem [0:DEPTH-1];
  reg  [PW-1:0] txWr_ff;
  reg  [PW-1:0] txRd_ff;
  reg  [PW:0] txCnt_ff;
  reg  [12:0] txShift_ff;
  reg  [3:0]  txLeft_ff;
  reg  [3:0]  txPhase_ff;
  reg         txBusy_ff;
  wire        txFull = (txCnt_ff == FULL_CNT);
  wire        txPush = wrTx & enable & ~txFull;
  wire        txPop  = enable & txEn_ff & ~brk_ff & ~txBusy_ff
                       & (txCnt_ff != {(PW+1){1'b0}});
  wire        txIdle = ~txBusy_ff & (txCnt_ff == {(PW+1){1'b0}});

  // Receive path state.
  reg         sync1_ff;
  reg         sync2_ff;
  reg         sync3_ff;
  reg         line_ff;
  reg  [1:0]  rxState_ff;
  reg  [3:0]  rxPhase_ff;
  reg  [3:0]  rxIdx_ff;
  reg  [11:0] rxBits_ff;
  reg         rxDone_ff;
  reg  [10:0] rxMem [0:DEPTH-1];
  reg  [PW-1:0] rxWr_ff;
  reg  [PW-1:0] rxRd_ff;
  reg  [PW:0] rxCnt_ff;
  // Last word handed to software; an empty read shows it again.
  reg  [8:0]  rxHeld_ff;
  wire        rxAvail = (rxCnt_ff != {(PW+1){1'b0}});
  wire        rxPop   = taken & read & (address == `REG_RXDATA) & rxAvail;
  wire        rxIdle  = (rxState_ff == RX_IDLE) | (rxState_ff == RX_WAIT);
  wire [10:0] rxTop   = rxMem[rxRd_ff];

  // Decode of a finished frame from the collected samples.
  wire [8:0] rxWord = (fmt == `FMT_9N) ? rxBits_ff[8:0] : {1'b0, rxBits_ff[7:0]};
  wire [3:0] stopAt = (fmt == `FMT_8N) ? 4'h8 : 4'h9;
  wire       rxFerr = ~rxBits_ff[stopAt] | (stop2 & ~rxBits_ff[stopAt + 4'h1]);
  wire       rxPerr = ((fmt == `FMT_8E) & (^rxBits_ff[8:0]))
                      | ((fmt == `FMT_8O) & ~(^rxBits_ff[8:0]));
  wire       rxBreak = rxFerr & (rxWord == 9'h000);
  wire       rxPush  = rxDone_ff & (rxCnt_ff != FULL_CNT);
  wire       rxOver  = rxDone_ff & (rxCnt_ff == FULL_CNT);
  wire [PW:0] rxAfter = rxCnt_ff + {{PW{1'b0}}, 1'b1} - {{PW{1'b0}}, rxPop};
  wire       isAddr  = addrDet_ff & (fmt == `FMT_9N) & rxWord[8];

  // Read multiplexer; parity and framing flags follow the word at the buffer head.
  reg [15:0] rdMux;
  always @*
  begin
    rdMux = 16'h0000;
    if (address == `REG_MODE)
    begin
      rdMux = modeReg_ff;
    end
    else if (address == `REG_STATUS)
    begin
      rdMux[`STA_TXISEL]  = txIsel_ff;
      rdMux[`STA_BREAK]   = brk_ff;
      rdMux[`STA_TXEN]    = txEn_ff;
      rdMux[`STA_TXFULL]  = txFull;
      rdMux[`STA_TXEMPTY] = txIdle;
      rdMux[`STA_RXISEL1] = rxIsel_ff[1];
      rdMux[`STA_RXISEL0] = rxIsel_ff[0];
      rdMux[`STA_ADDR]    = addrDet_ff;
      rdMux[`STA_RXIDLE]  = rxIdle;
      rdMux[`STA_PARITY_ERROR_FLAG]    = rxAvail & rxTop[9];
      rdMux[`STA_FRAMING_ERROR_FLAG]    = rxAvail & rxTop[10];
      rdMux[`STA_OVERRUN_FLAG]    = overrun_flag_ff;
      rdMux[`STA_RXAVAIL] = rxAvail;
    end
    else if (address == `REG_RXDATA)
    begin
      rdMux = {7'h00, (rxAvail ? rxTop[8:0] : rxHeld_ff)};
    end
    else if (address == `REG_BAUD)
    begin
      rdMux = baudDiv_ff;
    end
    else
    begin
      rdMux = 16'h0000;
    end
  end

  // Bus handshake: one wait cycle, then a one-cycle low waitrequest.
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      waitrequest <= 1'b1;
      readdata    <= 16'h0000;
    end
    else
    begin
      waitrequest <= ~((read | write) & waitrequest);
      if (read & waitrequest)
      begin
        readdata <= rdMux;
      end
    end
  end

  // Software-visible settings. Disable clears only break, transmit enable and the overrun flag.
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      modeReg_ff <= `MODE_RST;
      baudDiv_ff <= `BAUD_RST;
      txIsel_ff  <= 1'b0;
      brk_ff     <= 1'b0;
      txEn_ff    <= 1'b0;
      rxIsel_ff  <= 2'h0;
      addrDet_ff <= 1'b0;
      overrun_flag_ff    <= 1'b0;
    end
    else
    begin
      if (wrMode)
      begin
        modeReg_ff <= writedata;
      end
      if (wrBaud)
      begin
        baudDiv_ff <= writedata;
      end
      if (wrSta)
      begin
        txIsel_ff  <= writedata[`STA_TXISEL];
        rxIsel_ff  <= writedata[`STA_RXISEL1:`STA_RXISEL0];
        addrDet_ff <= writedata[`STA_ADDR];
      end
      if (!enable)
      begin
        brk_ff  <= 1'b0;
        txEn_ff <= 1'b0;
        overrun_flag_ff <= 1'b0;
      end
      else
      begin
        if (wrSta)
        begin
          brk_ff  <= writedata[`STA_BREAK];
          txEn_ff <= writedata[`STA_TXEN];
        end
        // A new overrun beats a simultaneous software clear.
        overrun_flag_ff <= rxOver | (overrun_flag_ff & ~(wrSta & ~writedata[`STA_OVERRUN_FLAG]));
      end
    end
  end

  // Baud divider counter.
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      baudCnt_ff <= 16'h0000;
    end
    else if (!enable || tick)
    begin
      baudCnt_ff <= 16'h0000;
    end
    else
    begin
      baudCnt_ff <= baudCnt_ff + 16'h0001;
    end
  end

  // Transmit buffer storage; no reset needed, pointers define content.
  always @(posedge core_clk)
  begin
    if (txPush)
    begin
      txMem[txWr_ff] <= writedata[8:0];
    end
  end

  // Transmit buffer pointers, shifter and serial output.
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txWr_ff    <= {PW{1'b0}};
      txRd_ff    <= {PW{1'b0}};
      txCnt_ff   <= {(PW+1){1'b0}};
      txShift_ff <= 13'h1fff;
      txLeft_ff  <= 4'h0;
      txPhase_ff <= 4'h0;
      txBusy_ff  <= 1'b0;
      txIrqPulse <= 1'b0;
      serialOut  <= 1'b1;
    end
    else if (!enable)
    begin
      txWr_ff    <= {PW{1'b0}};
      txRd_ff    <= {PW{1'b0}};
      txCnt_ff   <= {(PW+1){1'b0}};
      txShift_ff <= 13'h1fff;
      txLeft_ff  <= 4'h0;
      txPhase_ff <= 4'h0;
      txBusy_ff  <= 1'b0;
      txIrqPulse <= 1'b0;
      serialOut  <= 1'b1;
    end
    else
    begin
      txCnt_ff <= txCnt_ff + {{PW{1'b0}}, txPush} - {{PW{1'b0}}, txPop};
      if (txPush)
      begin
        txWr_ff <= txWr_ff + {{(PW-1){1'b0}}, 1'b1};
      end
      // Transfer pulse; in select-1 mode only when the buffer drains.
      txIrqPulse <= txPop & (~txIsel_ff | (txCnt_ff == {{PW{1'b0}}, 1'b1}));
      if (txPop)
      begin
        // Phase starts cleared, so the first bit ends 16 ticks later.
        txRd_ff    <= txRd_ff + {{(PW-1){1'b0}}, 1'b1};
        txShift_ff <= frameBits(txMem[txRd_ff], fmt);
        txLeft_ff  <= fLen;
        txPhase_ff <= 4'h0;
        txBusy_ff  <= 1'b1;
      end
      else if (txBusy_ff && tick)
      begin
        txPhase_ff <= txPhase_ff + 4'h1;
        if (txPhase_ff == `TICK_LAST)
        begin
          txShift_ff <= {1'b1, txShift_ff[12:1]};
          txLeft_ff  <= txLeft_ff - 4'h1;
          if (txLeft_ff == 4'h1)
          begin
            txBusy_ff <= 1'b0;
          end
        end
      end
      // Break overrides whatever the shifter is doing.
      if (brk_ff)
      begin
        serialOut <= 1'b0;
      end
      else if (txBusy_ff)
      begin
        serialOut <= txShift_ff[0];
      end
      else
      begin
        serialOut <= 1'b1;
      end
    end
  end

  // Input synchroniser; a change counts once stages two and three agree.
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_ff <= 1'b1;
      sync2_ff <= 1'b1;
      sync3_ff <= 1'b1;
      line_ff  <= 1'b1;
    end
    else
    begin
      sync1_ff <= serialIn;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      if (sync2_ff == sync3_ff)
      begin
        line_ff <= sync3_ff;
      end
    end
  end

  // Receive storage; each entry keeps its own error flags.
  always @(posedge core_clk)
  begin
    if (enable && rxPush)
    begin
      rxMem[rxWr_ff] <= {rxFerr, rxPerr, rxWord};
    end
  end

  // Receive state machine, buffer pointers and receive pulse.
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxState_ff <= RX_IDLE;
      rxPhase_ff <= 4'h0;
      rxIdx_ff   <= 4'h0;
      rxBits_ff  <= 12'h000;
      rxHeld_ff  <= 9'h000;
      rxDone_ff  <= 1'b0;
      rxWr_ff    <= {PW{1'b0}};
      rxRd_ff    <= {PW{1'b0}};
      rxCnt_ff   <= {(PW+1){1'b0}};
      rxIrqPulse <= 1'b0;
    end
    else if (!enable)
    begin
      rxState_ff <= RX_IDLE;
      rxPhase_ff <= 4'h0;
      rxIdx_ff   <= 4'h0;
      rxDone_ff  <= 1'b0;
      rxWr_ff    <= {PW{1'b0}};
      rxRd_ff    <= {PW{1'b0}};
      rxCnt_ff   <= {(PW+1){1'b0}};
      rxIrqPulse <= 1'b0;
    end
    else
    begin
      rxDone_ff <= 1'b0;
      if (rxPop)
      begin
        rxRd_ff <= rxRd_ff + {{(PW-1){1'b0}}, 1'b1};
        rxHeld_ff <= rxTop[8:0];
      end
      rxCnt_ff <= rxCnt_ff + {{PW{1'b0}}, rxPush} - {{PW{1'b0}}, rxPop};
      if (rxPush)
      begin
        rxWr_ff <= rxWr_ff + {{(PW-1){1'b0}}, 1'b1};
      end
      // With address detect in 9-bit format only address words pulse; otherwise the select field decides.
      if (addrDet_ff && fmt == `FMT_9N)
      begin
        rxIrqPulse <= rxPush & isAddr;
      end
      else
      begin
        rxIrqPulse <= rxPush & (~rxIsel_ff[1]
                      | (~rxIsel_ff[0] & (rxAfter == 3'h3))
                      | (rxIsel_ff[0] & (rxAfter == 3'h4)));
      end
      case (rxState_ff)
        RX_IDLE:
        begin
          if (rxDone_ff && rxBreak)
          begin
            rxState_ff <= RX_WAIT;
          end
          else if (!overrun_flag_ff && !line_ff)
          begin
            rxState_ff <= RX_START;
            rxPhase_ff <= 4'h0;
          end
        end
        RX_START:
        begin
          if (tick)
          begin
            rxPhase_ff <= rxPhase_ff + 4'h1;
            if (rxPhase_ff == `TICK_MID)
            begin
              // A glitch shorter than half a bit is not a start bit.
              rxState_ff <= line_ff ? RX_IDLE : RX_DATA;
              rxPhase_ff <= 4'h0;
              rxIdx_ff   <= 4'h0;
            end
          end
        end
        RX_DATA:
        begin
          if (tick)
          begin
            rxPhase_ff <= rxPhase_ff + 4'h1;
            if (rxPhase_ff == `TICK_LAST)
            begin
              rxBits_ff[rxIdx_ff] <= line_ff;
              rxIdx_ff <= rxIdx_ff + 4'h1;
              if (rxIdx_ff == fLen - 4'h2)
              begin
                rxDone_ff  <= 1'b1;
                rxState_ff <= RX_IDLE;
              end
            end
          end
        end
        default:
        begin
          if (line_ff)
          begin
            rxState_ff <= RX_IDLE;
          end
        end
      endcase
    end
  end

endmodule // async_serial_transceiver

// ### tb/serial_chk.sv
// Checker for the transceiver's register bus answer and its line output.
// Assumes it is bound to the transceiver top and sees only its ports.
`timescale 1ns/1ps
module serial_chk (
  input wire        core_clk,
  input wire        rst_n,
  input wire [2:0]  address,
  input wire        read,
  input wire        write,
  input wire [15:0] writedata,
  input wire [15:0] readdata,
  input wire        waitrequest,
  input wire        serialIn,
  input wire        serialOut,
  input wire        txIrqPulse,
  input wire        rxIrqPulse
);
  reg  en_ff;
  reg  brk_ff;
  wire takeWr = write && !waitrequest;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Shadow of enable and break, so the line is judged against what software asked.
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_ff  <= 1'b0;
      brk_ff <= 1'b0;
    end
    else if (takeWr && address == 3'h0)
    begin
      en_ff  <= writedata[15];
      brk_ff <= brk_ff & writedata[15];
    end
    else if (takeWr && address == 3'h1)
      brk_ff <= writedata[11] & en_ff;
  end
  wait_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus request not answered on the next cycle");
  wait_pulse_a: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  wait_idle_a: assert property (!(read || write) |=> waitrequest)
    else $error("waitrequest low without a request");
  unmapped_zero_a: assert property (read && !waitrequest && address > 3'h4
    |-> readdata == 16'h0000)
    else $error("unmapped index read not zero");
  rd_hold_a: assert property ($changed(readdata) |-> $past(read))
    else $error("read data changed without a read");
  break_low_a: assert property (brk_ff && $past(brk_ff, 2) |-> serialOut == 1'b0)
    else $error("line not low during break");
  tx_pulse_a: assert property (txIrqPulse |=> !txIrqPulse)
    else $error("transmit event longer than one cycle");
  rx_pulse_a: assert property (rxIrqPulse |=> !rxIrqPulse)
    else $error("receive event longer than one cycle");
  tx_bit_min_a: assert property ($fell(serialOut) |-> !serialOut [*8])
    else $error("low line level shorter than a bit");
  tx_high_min_a: assert property ($rose(serialOut) |-> serialOut [*8])
    else $error("high line level shorter than a bit");
endmodule // serial_chk

bind async_serial_transceiver serial_chk serial_chk_inst (
  .core_clk(core_clk), .rst_n(rst_n), .address(address), .read(read),
  .write(write), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .serialIn(serialIn), .serialOut(serialOut),
  .txIrqPulse(txIrqPulse), .rxIrqPulse(rxIrqPulse));

// ### tb/remote_serial.sv
// Remote serial device on the line: sends frames and decodes 8N1 frames.
// Assumes a divider of zero, so one bit lasts sixteen core clocks.
`timescale 1ns/1ps
module remote_serial #(
  parameter BIT = 16
)(
  input  wire       core_clk,
  input  wire       lineIn,
  output reg        lineOut,
  output reg        gotValid,
  output reg  [7:0] gotData
);
  reg [7:0] sh;
  integer   i;
  initial
  begin
    lineOut  = 1'b1;
    gotValid = 1'b0;
    gotData  = 8'h00;
  end
  // Sends a start bit then n bits LSB first, and idles high for two bits after.
  task send(input [15:0] b, input integer n);
    integer t;
    begin
      lineOut <= 1'b0;
      repeat (BIT) @(posedge core_clk);
      for (t = 0; t < n; t = t + 1)
      begin
        lineOut <= b[t];
        repeat (BIT) @(posedge core_clk);
      end
      lineOut <= 1'b1;
      repeat (2 * BIT) @(posedge core_clk);
    end
  endtask
  // Mid-bit sampling; a low stop is a break, so wait for the line to come back.
  initial forever
  begin
    @(negedge lineIn);
    repeat (BIT / 2) @(posedge core_clk);
    for (i = 0; i < 8; i = i + 1)
    begin
      repeat (BIT) @(posedge core_clk);
      sh[i] = lineIn;
    end
    repeat (BIT) @(posedge core_clk);
    if (lineIn)
    begin
      gotData  <= sh;
      gotValid <= 1'b1;
      @(posedge core_clk);
      gotValid <= 1'b0;
    end
    else
      wait (lineIn);
  end
endmodule // remote_serial

// ### tb/tb.sv
// Self-checking bench for the serial transceiver, bus master and line peer.
// Assumes the checker is bound to the design and the peer model is compiled.
`timescale 1ns/1ps
module tb;
  reg         core_clk;
  reg         rst_n;
  reg  [2:0]  address;
  reg         read;
  reg         write;
  reg  [15:0] writedata;
  wire [15:0] readdata;
  wire        waitrequest;
  wire        serialIn;
  wire        serialOut;
  wire        txIrqPulse;
  wire        rxIrqPulse;
  wire        gotValid;
  wire [7:0]  gotData;
  integer     errorCnt;
  integer     testsRun;
  integer     cycles;
  integer     seed;
  integer     txCnt;
  integer     rxCnt;
  integer     k;
  integer     j;
  integer     fn;
  reg  [31:0] e;
  reg  [15:0] fb;
  reg  [15:0] d[0:5];
  reg  [31:0] rq[$];
  reg  [15:0] tq[$];
  async_serial_transceiver async_serial_transceiver_inst (.core_clk(core_clk),
    .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .serialIn(serialIn), .serialOut(serialOut), .txIrqPulse(txIrqPulse),
    .rxIrqPulse(rxIrqPulse));
  remote_serial remote_serial_inst (.core_clk(core_clk), .lineIn(serialOut),
    .lineOut(serialIn), .gotValid(gotValid), .gotData(gotData));
  initial core_clk = 1'b0;
  // Free-running 50 MHz clock.
  always #10 core_clk = ~core_clk;
  task check(input [15:0] seen, input [15:0] exp);
    begin
      testsRun = testsRun + 1;
      if (seen !== exp)
      begin
        errorCnt = errorCnt + 1;
        $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task completeRun;
    begin
      if (errorCnt == 0 && testsRun > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // One bus cycle; a read notes its masked expectation before it starts.
  task bus(input w, input [2:0] a, input [15:0] v, input [15:0] m);
    begin
      if (!w)
        rq.push_back({m, v});
      address   <= a;
      writedata <= v;
      write     <= w;
      read      <= !w;
      @(posedge core_clk);
      while (waitrequest !== 1'b0)
        @(posedge core_clk);
      write <= 1'b0;
      read  <= 1'b0;
      @(posedge core_clk);
    end
  endtask
  // Builds a receive frame for format f; sb is the last stop, bp spoils parity.
  task rxf(input [1:0] f, input s2, input [8:0] x, input sb, input bp);
    begin
      fb = (f == 2'h0) ? {8'h00, x[7:0]} : (f == 2'h3) ? {7'h00, x} :
           {7'h00, ^x[7:0] ^ (f == 2'h2) ^ bp, x[7:0]};
      fn = (f == 2'h0) ? 8 : 9;
      fb[fn] = s2 ? 1'b1 : sb;
      fb[fn + 1] = sb;
      fn = fn + 1 + s2;
      remote_serial_inst.send(fb, fn);
    end
  endtask
  // Result watcher, event counters and the hang limit.
  always @(posedge core_clk)
  begin
    cycles = cycles + 1;
    txCnt = txCnt + (txIrqPulse === 1'b1);
    rxCnt = rxCnt + (rxIrqPulse === 1'b1);
    if (read && waitrequest === 1'b0)
    begin
      e = rq.pop_front();
      check(readdata & e[31:16], e[15:0]);
    end
    if (gotValid === 1'b1)
      check({8'h00, gotData}, tq.pop_front());
    if (cycles > 20000)
    begin
      errorCnt = errorCnt + 1;
      completeRun;
    end
  end
  // Main sequence.
  initial
  begin
    rst_n = 1'b0;
    address = 3'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 16'h0000;
    {errorCnt, testsRun, cycles, txCnt, rxCnt} = 0;
    seed = 79;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    bus(0, 3'h0, 16'h0000, 16'hffff);
    bus(0, 3'h1, 16'h0110, 16'hffff);
    bus(1, 3'h5, 16'hffff, 16'h0000);
    bus(0, 3'h5, 16'h0000, 16'hffff);
    bus(1, 3'h4, 16'h0000, 16'h0000);
    bus(1, 3'h0, 16'h8000, 16'h0000);
    // Fill the transmitter under both event selects; the sixth word is dropped.
    for (k = 0; k < 2; k = k + 1)
    begin
      bus(1, 3'h1, {k[0], 15'h0400}, 16'h0000);
      txCnt = 0;
      for (j = 0; j < 6; j = j + 1)
      begin
        d[j] = $random(seed) & 16'h00ff;
        if (j < 5)
          tq.push_back(d[j]);
        bus(1, 3'h2, d[j], 16'h0000);
        if (j == 4)
          bus(0, 3'h1, 16'h0200, 16'h0200);
      end
      repeat (900) @(posedge core_clk);
      check(txCnt[15:0], (k == 0) ? 16'h0005 : 16'h0002);
      bus(0, 3'h1, {k[0], 15'h0510}, 16'hffff);
    end
    // A break longer than thirteen bits must raise no transmit event.
    txCnt = 0;
    bus(1, 3'h1, 16'h0c00, 16'h0000);
    repeat (224) @(posedge core_clk);
    bus(1, 3'h1, 16'h0400, 16'h0000);
    repeat (48) @(posedge core_clk);
    check(txCnt[15:0], 16'h0000);
    // Four words under the three-word select, then read one past empty.
    rxCnt = 0;
    bus(1, 3'h1, 16'h0480, 16'h0000);
    for (j = 0; j < 4; j = j + 1)
    begin
      d[j] = $random(seed) & 16'h00ff;
      rxf(2'h0, 1'b0, d[j][8:0], 1'b1, 1'b0);
    end
    check(rxCnt[15:0], 16'h0001);
    bus(0, 3'h1, 16'h0001, 16'h0001);
    for (j = 0; j < 5; j = j + 1)
      bus(0, 3'h3, d[(j < 4) ? j : 3], 16'hffff);
    bus(0, 3'h1, 16'h0000, 16'h0001);
    // Overrun: buffer full after four frames, the fifth overruns and the sixth is ignored.
    bus(1, 3'h1, 16'h0400, 16'h0000);
    for (j = 0; j < 6; j = j + 1)
    begin
      d[j] = $random(seed) & 16'h00ff;
      rxf(2'h0, 1'b0, d[j][8:0], 1'b1, 1'b0);
    end
    bus(0, 3'h1, 16'h0003, 16'h0003);
    for (j = 0; j < 4; j = j + 1)
      bus(0, 3'h3, d[j], 16'hffff);
    bus(1, 3'h1, 16'h0400, 16'h0000);
    bus(0, 3'h1, 16'h0000, 16'h0003);
    // Every format and stop count: a clean word, then one with errors.
    for (k = 0; k < 8; k = k + 1)
    begin
      bus(1, 3'h0, {13'h1000, k[1:0], k[2]}, 16'h0000);
      d[0] = $random(seed) & ((k[1:0] == 2'h3) ? 16'h01ff : 16'h00ff);
      d[1] = $random(seed) & ((k[1:0] == 2'h3) ? 16'h01ff : 16'h00ff);
      rxf(k[1:0], k[2], d[0][8:0], 1'b1, 1'b0);
      rxf(k[1:0], k[2], d[1][8:0], 1'b0, 1'b1);
      bus(0, 3'h1, 16'h0001, 16'h000d);
      bus(0, 3'h3, d[0], 16'hffff);
      bus(0, 3'h1, {12'h000, k[1] ^ k[0], 3'h5}, 16'h000d);
      bus(0, 3'h3, d[1], 16'hffff);
    end
    // A long low line becomes a zero word with a framing error.
    bus(1, 3'h0, 16'h8000, 16'h0000);
    // The receiver must read busy while the long low level is being sampled.
    fork
      remote_serial_inst.send(16'h0000, 16);
      begin
        repeat (60) @(posedge core_clk);
        bus(0, 3'h1, 16'h0000, 16'h0010);
      end
    join
    bus(0, 3'h1, 16'h0015, 16'h0015);
    bus(0, 3'h3, 16'h0000, 16'hffff);
    bus(0, 3'h1, 16'h0010, 16'h0011);
    // Address detect: only the word with the ninth bit set raises an event.
    bus(1, 3'h0, 16'h8006, 16'h0000);
    bus(1, 3'h1, 16'h04e0, 16'h0000);
    rxCnt = 0;
    rxf(2'h3, 1'b0, 9'h1a5, 1'b1, 1'b0);
    rxf(2'h3, 1'b0, 9'h05a, 1'b1, 1'b0);
    check(rxCnt[15:0], 16'h0001);
    // Disable with words held: selects and address detect stay; transmit enable, buffers and flags clear.
    bus(1, 3'h0, 16'h0006, 16'h0000);
    bus(0, 3'h1, 16'h01f0, 16'hffff);
    bus(0, 3'h0, 16'h0006, 16'hffff);
    // A reset in mid-run with a word held returns power-on values.
    bus(1, 3'h0, 16'h8000, 16'h0000);
    rxf(2'h0, 1'b0, 9'h033, 1'b1, 1'b0);
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    bus(0, 3'h1, 16'h0110, 16'hffff);
    bus(0, 3'h0, 16'h0000, 16'hffff);
    completeRun;
  end
endmodule // tb
